/* File: pmu_regs_pkg.sv */
package pmu_regs_pkg;

    // Register addresses on the serial port.
    localparam logic [4:0] ADDR_BUCK3_VOLT = 5'h00;
    localparam logic [4:0] ADDR_BUCK1_VOLT = 5'h07;
    localparam logic [4:0] ADDR_BUCK2_VOLT = 5'h08;
    localparam logic [4:0] ADDR_BUCK3_STBY = 5'h09;
    localparam logic [4:0] ADDR_COMP_CTRL = 5'h0B;
    localparam logic [4:0] ADDR_INT_ENABLE = 5'h0C;
    localparam logic [4:0] ADDR_INT_STATUS = 5'h0D;
    localparam logic [4:0] ADDR_MISC_CTRL = 5'h0E;

    // Field positions inside the control registers.
    localparam int COMP_HYST_BIT = 7;
    localparam int COMP_THR_MSB = 6;
    localparam int COMP_THR_LSB = 1;
    localparam int COMP_EN_BIT = 0;
    localparam int MISC_SLEEP_BIT = 1;
    localparam int MISC_POL_BIT = 0;
    localparam int INT_SRC_MSB = 4;
    localparam int BUCK12_MSB = 5;
    localparam int BUCK3_MSB = 6;

    // Reset values.
    localparam logic COMP_HYST_RST = 1'b0;
    localparam logic [5:0] COMP_THR_RST = 6'h19;
    localparam logic COMP_EN_RST = 1'b1;
    localparam logic [4:0] INT_EN_RST = 5'h01;
    localparam logic LDO_SLEEP_RST = 1'b0;
    localparam logic IRQ_POL_RST = 1'b0;
    localparam logic IRQ_PIN_RST = 1'b1;
    localparam logic [5:0] BUCK1_RST = 6'h26;
    localparam logic [5:0] BUCK2_RST = 6'h26;
    localparam logic [6:0] BUCK3_RST = 7'h64;
    localparam logic [6:0] BUCK3_STBY_RST = 7'h53;

    // Serial frame layout.
    localparam logic [1:0] CMD_WRITE = 2'h2;
    localparam logic [1:0] CMD_READ = 2'h3;
    localparam logic [3:0] HDR_BITS = 4'h7;
    localparam logic [3:0] FRAME_BITS = 4'hF;

    // Code to millivolt mapping constants.
    localparam logic [11:0] BUCK12_BASE_MV = 12'd1100;
    localparam logic [11:0] BUCK12_STEP_MV = 12'd50;
    localparam logic [11:0] BUCK12_MAX_MV = 12'd3600;
    localparam logic [5:0] BUCK12_SAT_CODE = 6'h32;
    localparam logic [11:0] BUCK3_BASE_MV = 12'd700;
    localparam logic [11:0] BUCK3_STEP_MV = 12'd5;

    // Positions of the pin inputs inside the synchroniser vector.
    localparam int SYN_SCLK = 0;
    localparam int SYN_CS = 1;
    localparam int SYN_DI = 2;
    localparam int SYN_COMP = 3;
    localparam int SYN_GOOD_LSB = 4;
    localparam int SYN_GOOD_MSB = 7;
    localparam int SYN_WIDTH = 8;

    // Serial frame states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HEADER,
        ST_WRITE,
        ST_READ,
        ST_SKIP
    } frame_state_type;

endpackage

/* File: pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// Two flip-flop synchroniser for a vector of independent pin levels.
module pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q; // First stage, read only by the second stage.
    logic [WIDTH-1:0] sync_q; // Second stage, safe for logic.
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_d;

    // Next values simply shift the pins one stage along.
    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    // Both stages clear on reset and hold while the clock enable is low.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (ce_i) begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;

endmodule
`default_nettype wire

/* File: pmu_control_register_bank.sv */
`timescale 1ns/1ps
`default_nettype none
// Register bank of the power-management unit, reached over a four-wire serial port.
module pmu_control_register_bank
    import pmu_regs_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    input wire logic SPI_SCLK_I,
    input wire logic SPI_CS_I,
    input wire logic SPI_DI_I,
    output logic SPI_DO_O,
    input wire logic COMP_OUT_I,
    input wire logic BUCK1_GOOD_I,
    input wire logic BUCK2_GOOD_I,
    input wire logic BUCK3_GOOD_I,
    input wire logic LINEAR_RAIL_GOOD_I,
    output logic COMP_HYST_DOUBLE_O,
    output logic [5:0] COMP_THRESHOLD_O,
    output logic TRIP_DETECTOR_ENABLE_O,
    output logic LDO_SLEEP_O,
    output logic IRQ_O,
    output logic [11:0] BUCK1_MV_O,
    output logic [11:0] BUCK2_MV_O,
    output logic [11:0] BUCK3_MV_O,
    output logic [11:0] BUCK3_STBY_MV_O
);

    logic [SYN_WIDTH-1:0] pins_async; // Raw pin levels.
    logic [SYN_WIDTH-1:0] pins_sync; // Pin levels after two flip-flops.
    logic sclk_s; // Synchronised serial clock.
    logic cs_s; // Synchronised chip select, high while a frame runs.
    logic di_s; // Synchronised serial data in.
    logic sclk_rise; // Serial clock rising edge seen this cycle.
    logic sclk_fall; // Serial clock falling edge seen this cycle.

    // Serial engine state.
    frame_state_type state_q, state_d;
    logic sclk_prev_q, sclk_prev_d; // Last synchronised serial clock level.
    logic [3:0] cnt_q, cnt_d; // Number of serial bits taken in this frame.
    logic [7:0] shin_q, shin_d; // Incoming shift register.
    logic [7:0] shout_q, shout_d; // Outgoing read data.
    logic [4:0] addr_q, addr_d; // Address latched from the header.
    logic do_q, do_d; // Serial data out level.

    // Register state.
    logic hyst_q, hyst_d; // Hysteresis doubling.
    logic [5:0] thr_q, thr_d; // Comparator threshold code.
    logic cen_q, cen_d; // Trip detector enable.
    logic [4:0] int_en_q, int_en_d; // Interrupt source enables.
    logic [4:0] status_q, status_d; // Live status levels.
    logic sleep_q, sleep_d; // Linear regulator sleep.
    logic pol_q, pol_d; // Interrupt polarity, one for active high.
    logic [5:0] buck1_q, buck1_d; // Buck 1 voltage code.
    logic [5:0] buck2_q, buck2_d; // Buck 2 voltage code.
    logic [6:0] buck3_q, buck3_d; // Buck 3 voltage code.
    logic [6:0] stby_q, stby_d; // Buck 3 standby voltage code.

    // Derived outputs.
    logic irq_q, irq_d;
    logic [11:0] mv1_q, mv1_d;
    logic [11:0] mv2_q, mv2_d;
    logic [11:0] mv3_q, mv3_d;
    logic [11:0] mvs_q, mvs_d;

    // Every pin crosses into the clock domain through two flip-flops.
    assign pins_async = {LINEAR_RAIL_GOOD_I, BUCK3_GOOD_I, BUCK2_GOOD_I, BUCK1_GOOD_I,
                         COMP_OUT_I, SPI_DI_I, SPI_CS_I, SPI_SCLK_I};

    pin_sync #(
        .WIDTH(SYN_WIDTH)
    ) u_pin_sync (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .ce_i(CE_I),
        .async_i(pins_async),
        .sync_o(pins_sync)
    );

    assign sclk_s = pins_sync[SYN_SCLK];
    assign cs_s = pins_sync[SYN_CS];
    assign di_s = pins_sync[SYN_DI];
    assign sclk_rise = sclk_s & ~sclk_prev_q;
    assign sclk_fall = ~sclk_s & sclk_prev_q;

    // Read multiplexer; unmapped addresses and unused bits read zero.
    function automatic logic [7:0] read_reg(input logic [4:0] a);
        logic [7:0] r;
        r = 8'h00;
        if (a == ADDR_COMP_CTRL) begin
            r[COMP_HYST_BIT] = hyst_q;
            r[COMP_THR_MSB:COMP_THR_LSB] = thr_q;
            r[COMP_EN_BIT] = cen_q;
        end else if (a == ADDR_INT_ENABLE) begin
            r[INT_SRC_MSB:0] = int_en_q;
        end else if (a == ADDR_INT_STATUS) begin
            r[INT_SRC_MSB:0] = status_q;
        end else if (a == ADDR_MISC_CTRL) begin
            r[MISC_SLEEP_BIT] = sleep_q;
            r[MISC_POL_BIT] = pol_q;
        end else if (a == ADDR_BUCK1_VOLT) begin
            r[BUCK12_MSB:0] = buck1_q;
        end else if (a == ADDR_BUCK2_VOLT) begin
            r[BUCK12_MSB:0] = buck2_q;
        end else if (a == ADDR_BUCK3_VOLT) begin
            r[BUCK3_MSB:0] = buck3_q;
        end else if (a == ADDR_BUCK3_STBY) begin
            r[BUCK3_MSB:0] = stby_q;
        end
        return r;
    endfunction

    // Buck 1 and 2 mapping: linear in 50 mV steps, flat at the top.
    function automatic logic [11:0] buck12_mv(input logic [5:0] c);
        logic [11:0] v;
        v = BUCK12_BASE_MV + 12'(BUCK12_STEP_MV * {6'h00, c});
        if (c >= BUCK12_SAT_CODE) begin
            v = BUCK12_MAX_MV;
        end
        return v;
    endfunction

    // Serial engine and register writes: computes every next value except status, interrupt and voltage outputs.
    always_comb begin
        logic [7:0] wdata;
        wdata = 8'h00;
        state_d = state_q;
        sclk_prev_d = sclk_s;
        cnt_d = cnt_q;
        shin_d = shin_q;
        shout_d = shout_q;
        addr_d = addr_q;
        do_d = do_q;
        hyst_d = hyst_q;
        thr_d = thr_q;
        cen_d = cen_q;
        int_en_d = int_en_q;
        sleep_d = sleep_q;
        pol_d = pol_q;
        buck1_d = buck1_q;
        buck2_d = buck2_q;
        buck3_d = buck3_q;
        stby_d = stby_q;
        if (!cs_s) begin
            // Frame closed: engine idles and data out rests low.
            state_d = ST_IDLE;
            cnt_d = 4'h0;
            do_d = 1'b0;
        end else begin
            if (state_q == ST_IDLE) begin
                state_d = ST_HEADER;
            end
            if (sclk_rise && state_q != ST_SKIP) begin
                // Data in is taken on the rising serial clock edge.
                shin_d = {shin_q[6:0], di_s};
                cnt_d = 4'(cnt_q + 4'h1);
                case (state_q)
                    ST_IDLE, ST_HEADER: begin
                        if (cnt_d == HDR_BITS) begin
                            addr_d = shin_d[4:0];
                            if (shin_d[6:5] == CMD_READ) begin
                                state_d = ST_READ;
                                shout_d = read_reg(shin_d[4:0]);
                                do_d = shout_d[7];
                            end else if (shin_d[6:5] == CMD_WRITE) begin
                                state_d = ST_WRITE;
                            end else begin
                                state_d = ST_SKIP;
                            end
                        end
                    end
                    ST_WRITE: begin
                        if (cnt_d == FRAME_BITS) begin
                            wdata = shin_d;
                            state_d = ST_SKIP;
                            if (addr_q == ADDR_COMP_CTRL) begin
                                hyst_d = wdata[COMP_HYST_BIT];
                                thr_d = wdata[COMP_THR_MSB:COMP_THR_LSB];
                                cen_d = wdata[COMP_EN_BIT];
                            end else if (addr_q == ADDR_INT_ENABLE) begin
                                int_en_d = wdata[INT_SRC_MSB:0];
                            end else if (addr_q == ADDR_MISC_CTRL) begin
                                sleep_d = wdata[MISC_SLEEP_BIT];
                                pol_d = wdata[MISC_POL_BIT];
                            end else if (addr_q == ADDR_BUCK1_VOLT) begin
                                buck1_d = wdata[BUCK12_MSB:0];
                            end else if (addr_q == ADDR_BUCK2_VOLT) begin
                                buck2_d = wdata[BUCK12_MSB:0];
                            end else if (addr_q == ADDR_BUCK3_VOLT) begin
                                buck3_d = wdata[BUCK3_MSB:0];
                            end else if (addr_q == ADDR_BUCK3_STBY) begin
                                stby_d = wdata[BUCK3_MSB:0];
                            end
                            // Status and unmapped addresses drop the data.
                        end
                    end
                    default: begin
                        state_d = state_q;
                    end
                endcase
            end else if (sclk_fall && state_q == ST_READ) begin
                // Read data moves out on the falling edge, most significant first.
                if (cnt_q == FRAME_BITS) begin
                    state_d = ST_SKIP;
                    do_d = 1'b0;
                end else if (cnt_q > HDR_BITS) begin
                    // The top bit stands through the fall after the header, so the host sees it at rise 8.
                    shout_d = {shout_q[6:0], 1'b0};
                    do_d = shout_q[6];
                end
            end
            if (state_q == ST_WRITE) begin
                do_d = 1'b0;
            end
        end
    end

    // Status, interrupt pin and voltage outputs.
    always_comb begin
        logic any_src;
        any_src = 1'b0;
        status_d = pins_sync[SYN_GOOD_MSB:SYN_COMP];
        any_src = |(status_q & int_en_q);
        irq_d = pol_q ? any_src : ~any_src;
        mv1_d = buck12_mv(buck1_q);
        mv2_d = buck12_mv(buck2_q);
        mv3_d = BUCK3_BASE_MV + 12'(BUCK3_STEP_MV * {5'h00, buck3_q});
        mvs_d = BUCK3_BASE_MV + 12'(BUCK3_STEP_MV * {5'h00, stby_q});
    end

    // All state loads on reset, then follows the next values while enabled.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state_q <= ST_IDLE;
            sclk_prev_q <= 1'b0;
            cnt_q <= 4'h0;
            shin_q <= 8'h00;
            shout_q <= 8'h00;
            addr_q <= 5'h00;
            do_q <= 1'b0;
            hyst_q <= COMP_HYST_RST;
            thr_q <= COMP_THR_RST;
            cen_q <= COMP_EN_RST;
            int_en_q <= INT_EN_RST;
            status_q <= 5'h00;
            sleep_q <= LDO_SLEEP_RST;
            pol_q <= IRQ_POL_RST;
            buck1_q <= BUCK1_RST;
            buck2_q <= BUCK2_RST;
            buck3_q <= BUCK3_RST;
            stby_q <= BUCK3_STBY_RST;
            irq_q <= IRQ_PIN_RST;
            mv1_q <= 12'h000;
            mv2_q <= 12'h000;
            mv3_q <= 12'h000;
            mvs_q <= 12'h000;
        end else if (CE_I) begin
            state_q <= state_d;
            sclk_prev_q <= sclk_prev_d;
            cnt_q <= cnt_d;
            shin_q <= shin_d;
            shout_q <= shout_d;
            addr_q <= addr_d;
            do_q <= do_d;
            hyst_q <= hyst_d;
            thr_q <= thr_d;
            cen_q <= cen_d;
            int_en_q <= int_en_d;
            status_q <= status_d;
            sleep_q <= sleep_d;
            pol_q <= pol_d;
            buck1_q <= buck1_d;
            buck2_q <= buck2_d;
            buck3_q <= buck3_d;
            stby_q <= stby_d;
            irq_q <= irq_d;
            mv1_q <= mv1_d;
            mv2_q <= mv2_d;
            mv3_q <= mv3_d;
            mvs_q <= mvs_d;
        end
    end

    // Outputs come straight from flip-flops.
    assign SPI_DO_O = do_q;
    assign COMP_HYST_DOUBLE_O = hyst_q;
    assign COMP_THRESHOLD_O = thr_q;
    assign TRIP_DETECTOR_ENABLE_O = cen_q;
    assign LDO_SLEEP_O = sleep_q;
    assign IRQ_O = irq_q;
    assign BUCK1_MV_O = mv1_q;
    assign BUCK2_MV_O = mv2_q;
    assign BUCK3_MV_O = mv3_q;
    assign BUCK3_STBY_MV_O = mvs_q;

endmodule
`default_nettype wire

/* File: pmu_control_register_bank_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the serial port and the configuration outputs of the register bank.
module pmu_bank_checker
    import pmu_regs_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic SPI_SCLK_I,
    input wire logic SPI_CS_I,
    input wire logic SPI_DI_I,
    input wire logic SPI_DO_O,
    input wire logic COMP_OUT_I,
    input wire logic BUCK1_GOOD_I,
    input wire logic BUCK2_GOOD_I,
    input wire logic BUCK3_GOOD_I,
    input wire logic LINEAR_RAIL_GOOD_I,
    input wire logic COMP_HYST_DOUBLE_O,
    input wire logic [5:0] COMP_THRESHOLD_O,
    input wire logic TRIP_DETECTOR_ENABLE_O,
    input wire logic LDO_SLEEP_O,
    input wire logic IRQ_O,
    input wire logic [11:0] BUCK1_MV_O,
    input wire logic [11:0] BUCK2_MV_O,
    input wire logic [11:0] BUCK3_MV_O,
    input wire logic [11:0] BUCK3_STBY_MV_O
);
    logic sclk_q, sclk_d; // Serial clock level one cycle ago.
    logic [3:0] cnt_q, cnt_d; // Serial clock rises seen in this frame.
    logic [1:0] cmd_q, cmd_d; // The two command bits of this frame.
    logic rise; // A serial clock rise inside a frame.
    logic [4:0] pins; // All status pin levels together.

    // Counts rises per frame and keeps the command bits.
    always_comb begin
        pins = {LINEAR_RAIL_GOOD_I, BUCK3_GOOD_I, BUCK2_GOOD_I, BUCK1_GOOD_I, COMP_OUT_I};
        rise = SPI_CS_I && SPI_SCLK_I && !sclk_q;
        sclk_d = SPI_SCLK_I;
        cnt_d = cnt_q;
        cmd_d = cmd_q;
        if (!SPI_CS_I) begin
            cnt_d = 4'h0;
        end else if (rise && cnt_q != 4'hF) begin
            cnt_d = cnt_q + 4'h1;
            cmd_d = (cnt_q < 4'h2) ? {cmd_q[0], SPI_DI_I} : cmd_q;
        end
    end

    // Registers the frame tracking state.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            sclk_q <= 1'b0;
            cnt_q <= 4'h0;
            cmd_q <= 2'h0;
        end else begin
            sclk_q <= sclk_d;
            cnt_q <= cnt_d;
            cmd_q <= cmd_d;
        end
    end

    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    rst_ctrl_a: assert property (
        $fell(RST_I) |-> COMP_THRESHOLD_O == 6'h19 && TRIP_DETECTOR_ENABLE_O && !COMP_HYST_DOUBLE_O && !LDO_SLEEP_O
        && IRQ_O) else $error("control outputs wrong after reset");
    rst_volt_a: assert property (
        $fell(RST_I) |=> BUCK1_MV_O == 12'hBB8 && BUCK2_MV_O == 12'hBB8 && BUCK3_MV_O == 12'h4B0
        && BUCK3_STBY_MV_O == 12'h45B) else $error("voltage outputs wrong after reset");
    cfg_hold_a: assert property (
        (!SPI_CS_I) [*6] |-> $stable(COMP_THRESHOLD_O) && $stable(TRIP_DETECTOR_ENABLE_O) && $stable(LDO_SLEEP_O)
        && $stable(COMP_HYST_DOUBLE_O) && $stable(BUCK1_MV_O) && $stable(BUCK3_MV_O)) else $error("config moved");
    buck12_range_a: assert property (
        !$past(RST_I) |-> BUCK1_MV_O >= 12'h44C && BUCK1_MV_O <= 12'hE10
        && (BUCK1_MV_O - 12'h44C) % 12'h032 == 12'h000
        && BUCK2_MV_O >= 12'h44C && BUCK2_MV_O <= 12'hE10) else $error("buck 1/2 voltage off grid");
    buck3_range_a: assert property (
        !$past(RST_I) |-> BUCK3_MV_O >= 12'h2BC && BUCK3_MV_O <= 12'h537
        && (BUCK3_MV_O - 12'h2BC) % 12'h005 == 12'h000
        && BUCK3_STBY_MV_O >= 12'h2BC && BUCK3_STBY_MV_O <= 12'h537) else $error("buck 3 voltage off grid");
    irq_quiet_a: assert property (
        ($stable(pins) && !SPI_CS_I) [*8] |-> $stable(IRQ_O)) else $error("interrupt moved without cause");
    do_write_a: assert property (
        SPI_CS_I && cnt_q >= 4'h2 && cmd_q == CMD_WRITE |-> !SPI_DO_O) else $error("data out high in write");
    do_header_a: assert property (
        rise && cnt_q < 4'h7 |-> !SPI_DO_O) else $error("data out high in header");
    do_hold_a: assert property (
        SPI_CS_I && cnt_q >= 4'h8 && SPI_SCLK_I && sclk_q |-> $stable(SPI_DO_O)) else $error("data out moved");
    do_idle_a: assert property (
        (!SPI_CS_I) [*5] |-> !SPI_DO_O) else $error("data out high outside frame");

    read_frame_c: cover property (rise && cnt_q == 4'hE && cmd_q == CMD_READ);
    write_frame_c: cover property (rise && cnt_q == 4'hE && cmd_q == CMD_WRITE);
    irq_edge_c: cover property ($rose(IRQ_O));
endmodule
`default_nettype wire

/* File: spi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Serial host controller that runs frames on the bank's four-wire port.
module spi_host_model
    import pmu_regs_pkg::*;
(
    input wire logic clk_i,
    output logic sclk_o,
    output logic cs_o,
    output logic di_o,
    input wire logic do_i
);
    // Idle levels: clock low and select inactive outside frames.
    initial begin
        sclk_o = 1'b0;
        cs_o = 1'b0;
        di_o = 1'b0;
    end

    // Shifts command, address and data out MSB first; nbits below 15 aborts the frame.
    task automatic frame(input logic [1:0] cmd, input logic [4:0] addr, input logic [7:0] wdat,
                         input int nbits, output logic [7:0] rdat, output logic do_bad);
        logic [14:0] bits;
        bits = {cmd, addr, wdat};
        rdat = 8'h00;
        do_bad = 1'b0;
        @(posedge clk_i);
        cs_o <= 1'b1;
        for (int i = 14; i > 14 - nbits; i--) begin
            repeat (3) @(posedge clk_i);
            di_o <= bits[i];
            repeat (3) @(posedge clk_i);
            sclk_o <= 1'b1;
            // Read data is taken at the rise, while the device holds it.
            if (i < 8) begin
                rdat[i] = do_i;
            end
            // The device must keep its data line low during a write.
            if (cmd == CMD_WRITE && do_i !== 1'b0) begin
                do_bad = 1'b1;
            end
            repeat (6) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
        repeat (6) @(posedge clk_i);
        cs_o <= 1'b0;
        di_o <= ~di_o;
        repeat (5) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

/* File: pmu_control_register_bank_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Drives the bank through serial frames and checks registers and pins.
module pmu_control_register_bank_tb_top;
    import pmu_regs_pkg::*;
    logic clk = 1'b0; // Bank clock.
    logic rst = 1'b1; // Bank reset.
    logic [4:0] pins = 5'h00; // Status pins: rail good 4..1, comparator 0.
    wire sclk, cs, di, dout, hyst, en, sleep, irq; // Port and control wires.
    wire [5:0] thr; // Threshold code.
    wire [11:0] b1, b2, b3, b3s; // Voltage targets.
    int err_total = 0; // Mismatches.
    int check_count = 0; // Comparisons.
    logic [4:0] t_addr [8] = '{ADDR_BUCK1_VOLT, ADDR_BUCK1_VOLT, ADDR_BUCK1_VOLT, ADDR_BUCK2_VOLT,
                               ADDR_BUCK2_VOLT, ADDR_BUCK3_VOLT, ADDR_BUCK3_VOLT, ADDR_BUCK3_STBY};
    logic [7:0] t_code [8] = '{8'h00, 8'h31, 8'h32, 8'h3F, 8'h01, 8'h00, 8'h7F, 8'h2E};

    // Makes the 40 MHz clock.
    initial begin
        forever #12.5 clk = ~clk;
    end

    pmu_control_register_bank DUT (.CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .SPI_SCLK_I(sclk), .SPI_CS_I(cs),
        .SPI_DI_I(di), .SPI_DO_O(dout), .COMP_OUT_I(pins[0]), .BUCK1_GOOD_I(pins[1]), .BUCK2_GOOD_I(pins[2]),
        .BUCK3_GOOD_I(pins[3]), .LINEAR_RAIL_GOOD_I(pins[4]), .COMP_HYST_DOUBLE_O(hyst), .COMP_THRESHOLD_O(thr),
        .TRIP_DETECTOR_ENABLE_O(en), .LDO_SLEEP_O(sleep), .IRQ_O(irq), .BUCK1_MV_O(b1), .BUCK2_MV_O(b2),
        .BUCK3_MV_O(b3), .BUCK3_STBY_MV_O(b3s));
    spi_host_model HOST (.clk_i(clk), .sclk_o(sclk), .cs_o(cs), .di_o(di), .do_i(dout));

    // Expected voltage from a code: linear, six-bit codes saturate.
    function automatic logic [11:0] want_mv(input logic [4:0] a, input logic [7:0] c);
        if (a == ADDR_BUCK3_VOLT || a == ADDR_BUCK3_STBY) begin
            return 12'h2BC + 12'h005 * {5'h00, c[6:0]};
        end
        return (c[5:0] >= 6'h32) ? 12'hE10 : 12'h44C + 12'h032 * {6'h00, c[5:0]};
    endfunction

    // Picks the voltage output that belongs to an address.
    function automatic logic [11:0] seen_mv(input logic [4:0] a);
        return (a == ADDR_BUCK1_VOLT) ? b1 : (a == ADDR_BUCK2_VOLT) ? b2 : (a == ADDR_BUCK3_VOLT) ? b3 : b3s;
    endfunction

    // Compares and reports one value.
    task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One write frame; data out must stay low throughout.
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic bad;
        HOST.frame(CMD_WRITE, a, d, 15, r, bad);
        chk("data out in write", 12'h000, {11'h000, bad});
    endtask

    // One read frame compared with an expected byte.
    task automatic rchk(input string nm, input logic [4:0] a, input logic [7:0] e);
        logic [7:0] r;
        logic bad;
        HOST.frame(CMD_READ, a, 8'h00, 15, r, bad);
        chk(nm, {4'h0, e}, {4'h0, r});
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        $display("BAD watchdog expected done seen running");
        wrap_up();
    end

    // Main sequence.
    initial begin
        logic [7:0] r;
        logic b;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk("threshold", 12'h019, {6'h00, thr});
        chk("hysteresis", 12'h000, {11'h000, hyst});
        chk("enable", 12'h001, {11'h000, en});
        chk("sleep", 12'h000, {11'h000, sleep});
        chk("interrupt idle", 12'h001, {11'h000, irq});
        rchk("comp ctrl", ADDR_COMP_CTRL, 8'h33);
        rchk("int enable", ADDR_INT_ENABLE, 8'h01);
        rchk("status", ADDR_INT_STATUS, 8'h00);
        rchk("misc", ADDR_MISC_CTRL, 8'h00);
        wr(ADDR_COMP_CTRL, 8'hFF);
        chk("threshold", 12'h03F, {6'h00, thr});
        chk("hysteresis", 12'h001, {11'h000, hyst});
        wr(ADDR_COMP_CTRL, 8'h80);
        chk("threshold", 12'h000, {6'h00, thr});
        chk("enable", 12'h000, {11'h000, en});
        rchk("comp ctrl", ADDR_COMP_CTRL, 8'h80);
        wr(ADDR_INT_ENABLE, 8'hFF);
        rchk("int enable", ADDR_INT_ENABLE, 8'h1F);
        wr(ADDR_MISC_CTRL, 8'hFE);
        rchk("misc", ADDR_MISC_CTRL, 8'h02);
        chk("sleep", 12'h001, {11'h000, sleep});
        // Each status source alone, with all enables set and the pin active low.
        for (int k = 0; k < 5; k++) begin
            pins <= 5'h01 << k;
            repeat (10) @(posedge clk);
            rchk("status", ADDR_INT_STATUS, 8'h01 << k);
            chk("interrupt low", 12'h000, {11'h000, irq});
        end
        wr(ADDR_MISC_CTRL, 8'h01);
        chk("interrupt high", 12'h001, {11'h000, irq});
        chk("sleep", 12'h000, {11'h000, sleep});
        pins <= 5'h01;
        wr(ADDR_INT_ENABLE, 8'h1E);
        chk("interrupt masked", 12'h000, {11'h000, irq});
        wr(ADDR_INT_ENABLE, 8'h01);
        chk("interrupt enabled", 12'h001, {11'h000, irq});
        pins <= 5'h00;
        repeat (10) @(posedge clk);
        chk("interrupt cleared", 12'h000, {11'h000, irq});
        wr(ADDR_INT_STATUS, 8'hFF);
        rchk("status", ADDR_INT_STATUS, 8'h00);
        // Boundary voltage codes of the buck 1, 2 and 3 registers, and one mid-range code of the standby register.
        for (int k = 0; k < 8; k++) begin
            wr(t_addr[k], t_code[k]);
            chk("voltage", want_mv(t_addr[k], t_code[k]), seen_mv(t_addr[k]));
            rchk("voltage code", t_addr[k], t_code[k]);
        end
        rchk("unmapped", 5'h1F, 8'h00);
        HOST.frame(2'b00, ADDR_MISC_CTRL, 8'hFE, 15, r, b);
        rchk("misc", ADDR_MISC_CTRL, 8'h01);
        HOST.frame(CMD_WRITE, ADDR_COMP_CTRL, 8'h3C, 12, r, b);
        rchk("comp ctrl", ADDR_COMP_CTRL, 8'h80);
        wrap_up();
    end
endmodule

bind pmu_control_register_bank pmu_bank_checker CHK (.CLK_I(CLK_I), .RST_I(RST_I), .SPI_SCLK_I(SPI_SCLK_I),
    .SPI_CS_I(SPI_CS_I), .SPI_DI_I(SPI_DI_I), .SPI_DO_O(SPI_DO_O), .COMP_OUT_I(COMP_OUT_I),
    .BUCK1_GOOD_I(BUCK1_GOOD_I), .BUCK2_GOOD_I(BUCK2_GOOD_I), .BUCK3_GOOD_I(BUCK3_GOOD_I),
    .LINEAR_RAIL_GOOD_I(LINEAR_RAIL_GOOD_I), .COMP_HYST_DOUBLE_O(COMP_HYST_DOUBLE_O),
    .COMP_THRESHOLD_O(COMP_THRESHOLD_O), .TRIP_DETECTOR_ENABLE_O(TRIP_DETECTOR_ENABLE_O),
    .LDO_SLEEP_O(LDO_SLEEP_O), .IRQ_O(IRQ_O), .BUCK1_MV_O(BUCK1_MV_O), .BUCK2_MV_O(BUCK2_MV_O),
    .BUCK3_MV_O(BUCK3_MV_O), .BUCK3_STBY_MV_O(BUCK3_STBY_MV_O));
`default_nettype wire
